/* design/safety_pkg.sv */
// Shared constants and carrier types for the safety acknowledge and delay block
package safety_pkg;

    // ****************************************************************
    // Time base
    // ****************************************************************
    localparam int CLK_KHZ = 40000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES_DEF = CLK_KHZ * TICK_MS;
    localparam int BLINK_HZ = 1;
    localparam int BLINK_HALF_TICKS = 1000 / (2 * BLINK_HZ * TICK_MS);
    localparam int BLINK_W = 6;

    // ****************************************************************
    // Acknowledge pulse limits
    // ****************************************************************
    localparam int NUM_EN = 7;
    localparam int ACK_MIN_SHORT_MS = 100;
    localparam int ACK_MIN_LONG_MS = 350;
    localparam int ACK_MAX_S = 30;
    localparam int PW_W = 12;
    localparam logic [PW_W-1:0] ACK_MIN_SHORT_TICKS =
        PW_W'((ACK_MIN_SHORT_MS + TICK_MS - 1) / TICK_MS);
    localparam logic [PW_W-1:0] ACK_MIN_LONG_TICKS =
        PW_W'((ACK_MIN_LONG_MS + TICK_MS - 1) / TICK_MS);
    localparam logic [PW_W-1:0] ACK_MAX_TICKS =
        PW_W'(ACK_MAX_S * 1000 / TICK_MS);

    // ****************************************************************
    // Delay limits
    // ****************************************************************
    localparam int NUM_SEL = 4;
    localparam int DLY_W = 16;
    localparam int SUM_W = 18;
    localparam int FIX_MAX_S = 300;
    localparam int ADJ_MAX_S = 600;
    localparam logic [DLY_W-1:0] FIX_MAX_TICKS =
        DLY_W'(FIX_MAX_S * 1000 / TICK_MS);
    localparam logic [DLY_W-1:0] ADJ_MAX_TICKS =
        DLY_W'(ADJ_MAX_S * 1000 / TICK_MS);

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_FIX_DELAY = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_ADJ_DELAY0 = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 8'h04;
    localparam int CTRL_EN_LSB = 0;
    localparam int CTRL_LONG_BIT = 8;
    localparam int CTRL_RUN_BIT = 16;
    localparam logic [NUM_EN-1:0] EN_MASK_RST = 7'h01;
    localparam logic [DLY_W-1:0] DELAY_RST = 16'h0000;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic [NUM_SEL-1:0] sel;
        logic ctrl_in;
        logic off_in;
        logic ack;
        logic [NUM_EN-1:0] enable;
    } pin_in_t;

    localparam int PIN_W = $bits(pin_in_t);

    typedef struct packed {
        logic fix_running;
        logic adj_running;
        logic time_change;
        logic adj_release;
        logic fix_release;
        logic ack_request;
        logic ack_release;
        logic cond_met;
    } status_t;

endpackage : safety_pkg

/* design/ack_unit.sv */
// Acknowledge unit: enable AND, pulse width check and release latch
`timescale 1ns/100ps
module ack_unit (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic tick,
    input wire logic [safety_pkg::NUM_EN-1:0] enable,
    input wire logic [safety_pkg::NUM_EN-1:0] enable_mask,
    input wire logic ack,
    input wire logic long_pulse,
    input wire logic blink,
    output logic cond_met,
    output logic release_out,
    output logic request
);
    logic [safety_pkg::PW_W-1:0] width_reg;
    logic [safety_pkg::PW_W-1:0] width_next;
    logic ack_prev_reg;
    logic cond_next;
    logic release_next;
    logic ack_fall;
    logic width_ok;
    logic [safety_pkg::PW_W-1:0] min_ticks;

    // Unused enables read as high; an empty mask never meets the condition
    assign cond_next = (&(enable | ~enable_mask)) & (|enable_mask);
    assign min_ticks = long_pulse ? safety_pkg::ACK_MIN_LONG_TICKS
                                  : safety_pkg::ACK_MIN_SHORT_TICKS;
    assign ack_fall = ack_prev_reg & ~ack;
    assign width_ok = (width_reg >= min_ticks) &&
                      (width_reg <= safety_pkg::ACK_MAX_TICKS);
    // Saturate one past the limit so an overlong press stays invalid
    assign width_next = !ack ? '0 :
        (tick && width_reg <= safety_pkg::ACK_MAX_TICKS) ?
            width_reg + 1'b1 : width_reg;
    assign release_next = !cond_next ? 1'b0 :
        (ack_fall && width_ok) ? 1'b1 : release_out;

    always_ff @(posedge mclk) begin
        if (!rst_n || clear) begin
            width_reg <= '0;
            ack_prev_reg <= 1'b0;
            cond_met <= 1'b0;
            release_out <= 1'b0;
            request <= 1'b0;
        end else begin
            width_reg <= width_next;
            ack_prev_reg <= ack;
            cond_met <= cond_next;
            release_out <= release_next;
            request <= cond_next & ~release_next & blink;
        end
    end

endmodule : ack_unit

/* design/delay_timer.sv */
// Switch-off delay timer: release held high, dropped after a delay
`timescale 1ns/100ps
module delay_timer (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic tick,
    input wire logic hold_in,
    input wire logic [safety_pkg::DLY_W-1:0] delay,
    output logic release_out,
    output logic running
);
    typedef enum logic [1:0] {REL_LOW, REL_HIGH, TIMING} timer_state_t;

    timer_state_t state_reg;
    timer_state_t state_next;
    logic [safety_pkg::DLY_W-1:0] count_reg;
    logic [safety_pkg::DLY_W-1:0] count_next;
    logic expire;

    assign expire = tick && (count_reg <= 16'h0001);

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        unique case (state_reg)
            REL_LOW: begin
                // Low after reset or run entry: no edge, no delay
                if (hold_in) begin
                    state_next = REL_HIGH;
                end
            end
            REL_HIGH: begin
                if (!hold_in) begin
                    count_next = delay;
                    state_next = (delay == '0) ? REL_LOW : TIMING;
                end
            end
            TIMING: begin
                if (hold_in) begin
                    count_next = '0;
                    state_next = REL_HIGH;
                end else if (expire) begin
                    count_next = '0;
                    state_next = REL_LOW;
                end else if (tick) begin
                    count_next = count_reg - 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n || clear) begin
            state_reg <= REL_LOW;
            count_reg <= '0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    // High input forces release in the same cycle
    assign release_out = hold_in || (state_reg != REL_LOW);
    assign running = (state_reg == TIMING);

endmodule : delay_timer

/* design/safety_ack_and_off_delay.sv */
// Top: acknowledge unit, fixed and adjustable switch-off delay timers
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/100ps
module safety_ack_and_off_delay #(
    parameter int TICK_CYCLES = safety_pkg::TICK_CYCLES_DEF
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [safety_pkg::ADDR_W-1:0] addr,
    input wire logic [safety_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [safety_pkg::DATA_W-1:0] rdata,
    input wire safety_pkg::pin_in_t pins,
    output logic cond_met,
    output logic ack_release,
    output logic ack_request,
    output logic fix_release,
    output logic adj_release,
    output logic time_change
);
    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    // Three stages; a change is taken only once stages two and three
    // agree, which also rejects a single-cycle glitch.
    logic [safety_pkg::PIN_W-1:0] sync1_reg;
    logic [safety_pkg::PIN_W-1:0] sync2_reg;
    logic [safety_pkg::PIN_W-1:0] sync3_reg;
    logic [safety_pkg::PIN_W-1:0] filt_reg;
    safety_pkg::pin_in_t pin_s;

    genvar gi;
    generate
        for (gi = 0; gi < safety_pkg::PIN_W; gi++) begin : g_sync
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                    sync3_reg[gi] <= 1'b0;
                    filt_reg[gi] <= 1'b0;
                end else begin
                    sync1_reg[gi] <= pins[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                    sync3_reg[gi] <= sync2_reg[gi];
                    if (sync2_reg[gi] == sync3_reg[gi]) begin
                        filt_reg[gi] <= sync3_reg[gi];
                    end
                end
            end
        end
    endgenerate

    assign pin_s = safety_pkg::pin_in_t'(filt_reg);

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [safety_pkg::NUM_EN-1:0] en_mask_reg;
    logic long_pulse_reg;
    logic run_reg;
    logic [safety_pkg::DLY_W-1:0] fix_delay_reg;
    logic [safety_pkg::DLY_W-1:0] adj_delay_reg [safety_pkg::NUM_SEL];
    logic [safety_pkg::DATA_W-1:0] rdata_next;
    logic [safety_pkg::DATA_W-1:0] adj_rdata [safety_pkg::NUM_SEL];
    logic [safety_pkg::NUM_SEL-1:0] adj_hit;
    logic wr_ctrl;
    logic wr_fix;
    logic [safety_pkg::DLY_W-1:0] wdata_dly;
    logic [safety_pkg::DLY_W-1:0] fix_wr_val;
    logic [safety_pkg::DLY_W-1:0] adj_wr_val;
    safety_pkg::status_t status;

    assign wr_ctrl = wr && (addr == safety_pkg::ADDR_CTRL);
    assign wr_fix = wr && (addr == safety_pkg::ADDR_FIX_DELAY);
    assign wdata_dly = wdata[safety_pkg::DLY_W-1:0];
    // Out-of-range delays are clamped so the counter never overruns
    assign fix_wr_val = (wdata[safety_pkg::DATA_W-1:safety_pkg::DLY_W] != '0
        || wdata_dly > safety_pkg::FIX_MAX_TICKS) ?
        safety_pkg::FIX_MAX_TICKS : wdata_dly;
    assign adj_wr_val = (wdata[safety_pkg::DATA_W-1:safety_pkg::DLY_W] != '0
        || wdata_dly > safety_pkg::ADJ_MAX_TICKS) ?
        safety_pkg::ADJ_MAX_TICKS : wdata_dly;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            en_mask_reg <= safety_pkg::EN_MASK_RST;
            long_pulse_reg <= 1'b0;
            run_reg <= 1'b0;
        end else if (wr_ctrl) begin
            en_mask_reg <= wdata[safety_pkg::CTRL_EN_LSB +:
                                 safety_pkg::NUM_EN];
            long_pulse_reg <= wdata[safety_pkg::CTRL_LONG_BIT];
            run_reg <= wdata[safety_pkg::CTRL_RUN_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fix_delay_reg <= safety_pkg::DELAY_RST;
        end else if (wr_fix) begin
            fix_delay_reg <= fix_wr_val;
        end
    end

    generate
        for (gi = 0; gi < safety_pkg::NUM_SEL; gi++) begin : g_adj_reg
            assign adj_hit[gi] = (addr == safety_pkg::ADDR_ADJ_DELAY0 +
                safety_pkg::ADDR_W'(gi) * safety_pkg::ADDR_STEP);
            assign adj_rdata[gi] = {{(safety_pkg::DATA_W -
                safety_pkg::DLY_W){1'b0}}, adj_delay_reg[gi]};
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    adj_delay_reg[gi] <= safety_pkg::DELAY_RST;
                end else if (wr && adj_hit[gi]) begin
                    adj_delay_reg[gi] <= adj_wr_val;
                end
            end
        end
    endgenerate

    // Unmapped addresses read as zero
    assign rdata_next =
        (addr == safety_pkg::ADDR_CTRL) ?
            safety_pkg::DATA_W'({run_reg, 7'h00, long_pulse_reg,
                                 1'b0, en_mask_reg}) :
        (addr == safety_pkg::ADDR_FIX_DELAY) ?
            safety_pkg::DATA_W'(fix_delay_reg) :
        adj_hit[0] ? adj_rdata[0] :
        adj_hit[1] ? adj_rdata[1] :
        adj_hit[2] ? adj_rdata[2] :
        adj_hit[3] ? adj_rdata[3] :
        (addr == safety_pkg::ADDR_STATUS) ?
            safety_pkg::DATA_W'(status) : '0;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (rd) begin
            rdata <= rdata_next;
        end else begin
            rdata <= '0;
        end
    end

    // ****************************************************************
    // Time base
    // ****************************************************************
    // Tick runs free even in stop, so timing phase is never reset by
    // software; the first tick after run entry may come early.
    localparam int DIV_W = $clog2(TICK_CYCLES + 1);
    logic [DIV_W-1:0] div_reg;
    logic tick;
    logic [safety_pkg::BLINK_W-1:0] blink_cnt_reg;
    logic blink_reg;
    logic blink_wrap;

    assign tick = (div_reg == DIV_W'(TICK_CYCLES - 1));
    assign blink_wrap = (blink_cnt_reg ==
        safety_pkg::BLINK_W'(safety_pkg::BLINK_HALF_TICKS - 1));

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            div_reg <= '0;
        end else if (tick) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            blink_cnt_reg <= '0;
            blink_reg <= 1'b0;
        end else if (tick) begin
            blink_cnt_reg <= blink_wrap ? '0 : blink_cnt_reg + 1'b1;
            if (blink_wrap) begin
                blink_reg <= ~blink_reg;
            end
        end
    end

    // ****************************************************************
    // Acknowledge unit
    // ****************************************************************
    // Also serves as the restart unit; only the naming would differ.
    logic stopped;

    assign stopped = ~run_reg;

    ack_unit u_ack (
        .mclk(mclk),
        .rst_n(rst_n),
        .clear(stopped),
        .tick(tick),
        .enable(pin_s.enable),
        .enable_mask(en_mask_reg),
        .ack(pin_s.ack),
        .long_pulse(long_pulse_reg),
        .blink(blink_reg),
        .cond_met(cond_met),
        .release_out(ack_release),
        .request(ack_request)
    );

    // ****************************************************************
    // Fixed switch-off delay
    // ****************************************************************
    logic fix_rel;
    logic fix_running;

    delay_timer u_fix (
        .mclk(mclk),
        .rst_n(rst_n),
        .clear(stopped),
        .tick(tick),
        .hold_in(pin_s.off_in & run_reg),
        .delay(fix_delay_reg),
        .release_out(fix_rel),
        .running(fix_running)
    );

    // ****************************************************************
    // Adjustable switch-off delay
    // ****************************************************************
    logic [safety_pkg::SUM_W-1:0] part_sum [safety_pkg::NUM_SEL+1];
    logic [safety_pkg::DLY_W-1:0] adj_sum;
    logic [safety_pkg::NUM_SEL-1:0] sel_active;
    logic [safety_pkg::NUM_SEL-1:0] sel_latch_reg;
    logic ctrl_prev_reg;
    logic ctrl_fall;
    logic adj_rel;
    logic adj_running;
    logic time_change_reg;
    logic adj_hold;

    assign part_sum[0] = '0;
    generate
        for (gi = 0; gi < safety_pkg::NUM_SEL; gi++) begin : g_sum
            // A zero delay leaves its select input inactive
            assign sel_active[gi] = pin_s.sel[gi] &&
                (adj_delay_reg[gi] != '0);
            assign part_sum[gi+1] = part_sum[gi] + (sel_active[gi] ?
                safety_pkg::SUM_W'(adj_delay_reg[gi]) : '0);
        end
    endgenerate

    assign adj_sum = (part_sum[safety_pkg::NUM_SEL] >
        safety_pkg::SUM_W'(safety_pkg::ADJ_MAX_TICKS)) ?
        safety_pkg::ADJ_MAX_TICKS :
        part_sum[safety_pkg::NUM_SEL][safety_pkg::DLY_W-1:0];

    assign adj_hold = pin_s.ctrl_in & run_reg;
    assign ctrl_fall = ctrl_prev_reg & ~adj_hold;

    delay_timer u_adj (
        .mclk(mclk),
        .rst_n(rst_n),
        .clear(stopped),
        .tick(tick),
        .hold_in(adj_hold),
        .delay(adj_sum),
        .release_out(adj_rel),
        .running(adj_running)
    );

    always_ff @(posedge mclk) begin
        if (!rst_n || stopped) begin
            ctrl_prev_reg <= 1'b0;
            sel_latch_reg <= '0;
        end else begin
            ctrl_prev_reg <= adj_hold;
            if (ctrl_fall) begin
                sel_latch_reg <= pin_s.sel;
            end
        end
    end

    // Change is flagged against the selection taken at the edge
    always_ff @(posedge mclk) begin
        if (!rst_n || stopped) begin
            time_change_reg <= 1'b0;
        end else if (adj_running && !ctrl_fall &&
                     pin_s.sel != sel_latch_reg) begin
            time_change_reg <= 1'b1;
        end else if (adj_hold) begin
            time_change_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // Outputs and status
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fix_release <= 1'b0;
            adj_release <= 1'b0;
        end else begin
            fix_release <= fix_rel;
            adj_release <= adj_rel;
        end
    end

    assign time_change = time_change_reg;

    assign status.fix_running = fix_running;
    assign status.adj_running = adj_running;
    assign status.time_change = time_change_reg;
    assign status.adj_release = adj_release;
    assign status.fix_release = fix_release;
    assign status.ack_request = ack_request;
    assign status.ack_release = ack_release;
    assign status.cond_met = cond_met;

endmodule : safety_ack_and_off_delay

/* testbench/safety_chk.sv */
// Port-level assertions for the safety acknowledge and delay block
`timescale 1ns/100ps
module safety_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire safety_pkg::pin_in_t pins,
    input wire logic cond_met,
    input wire logic ack_release,
    input wire logic ack_request,
    input wire logic fix_release,
    input wire logic adj_release,
    input wire logic time_change
);
    // ********
    // Run shadow
    // ********
    logic run_reg;
    wire run_wr = wr && addr == safety_pkg::ADDR_CTRL;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            run_reg <= 1'h0;
        end else if (run_wr) begin
            run_reg <= wdata[safety_pkg::CTRL_RUN_BIT];
        end
    end
    // Pin filters add several cycles, so hold times are generous
    sequence s_off_high;
        (run_reg && pins.off_in) [*8];
    endsequence
    sequence s_ctrl_high;
        (run_reg && pins.ctrl_in) [*8];
    endsequence
    a_rdata_idle:
        assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data not zero outside a read");
    a_rel_cond:
        assert property ($rose(ack_release) |-> cond_met)
        else $error("release rose without condition");
    a_req_off:
        assert property (ack_release && $past(ack_release) |-> !ack_request)
        else $error("request lamp on while released");
    a_drop_rel:
        assert property (!cond_met [*2] |-> !ack_release)
        else $error("release held with condition low");
    a_fix_high:
        assert property (s_off_high |=> fix_release)
        else $error("fixed release low with input high");
    a_adj_high:
        assert property (s_ctrl_high |=> adj_release && !time_change)
        else $error("adjustable outputs wrong with control high");
    a_stop_quiet:
        assert property (!run_reg [*3] |-> !(ack_release || fix_release
            || adj_release || time_change))
        else $error("output active in stop state");
    a_adj_low:
        assert property ((!pins.ctrl_in) [*6] ##0 !adj_release
            |=> !adj_release)
        else $error("adjustable release rose with control low");
    a_fix_low:
        assert property ((!pins.off_in) [*6] ##0 !fix_release
            |=> !fix_release)
        else $error("fixed release rose with input low");
endmodule : safety_chk

bind safety_ack_and_off_delay safety_chk chk_u (.mclk, .rst_n, .addr,
    .wdata, .wr, .rd, .rdata, .pins, .cond_met, .ack_release,
    .ack_request, .fix_release, .adj_release, .time_change);

/* testbench/op_panel.sv */
// Application logic and pushbuttons that drive the pin inputs
`timescale 1ns/100ps
module op_panel (
    input wire logic mclk,
    input wire safety_pkg::pin_in_t want,
    output safety_pkg::pin_in_t pins
);
    // Levels move just after an edge and last many cycles
    always @(posedge mclk) begin
        pins <= want;
    end
endmodule : op_panel

/* testbench/safety_ack_and_off_delay_tb.sv */
// Self-checking bench for the acknowledge unit and off-delay timers
`timescale 1ns/100ps
module safety_ack_and_off_delay_tb;
    // ********
    // Harness
    // ********
    localparam int TC = 4;
    logic mclk = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'h0;
    logic rd = 1'h0;
    logic [31:0] rdata;
    safety_pkg::pin_in_t want = '0;
    safety_pkg::pin_in_t pins;
    logic cond_met, ack_release, ack_request;
    logic fix_release, adj_release, time_change;
    logic [5:0] outs;
    int failures = 0;
    int checked = 0;
    int n;
    assign outs = {time_change, adj_release, fix_release, ack_request,
        ack_release, cond_met};
    op_panel pan_u (.mclk, .want, .pins);
    safety_ack_and_off_delay #(.TICK_CYCLES(TC)) dut_u (.mclk, .rst_n,
        .addr, .wdata, .wr, .rd, .rdata, .pins, .cond_met, .ack_release,
        .ack_request, .fix_release, .adj_release, .time_change);
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
    endtask : cyc
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        cyc(1);
        wr <= 1'h0;
        cyc(1);
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        addr <= a;
        rd <= 1'h1;
        cyc(1);
        rd <= 1'h0;
        #1 chk(rdata, e);
        cyc(1);
    endtask : rd_chk
    // Bounded so a stuck output cannot hang the run
    task automatic wait_for(input int w, input logic v);
        n = 0;
        while (outs[w] !== v && n < 4000) begin
            cyc(1);
            n++;
        end
        if (n >= 4000) begin
            failures++;
            $display("CHECK FAILED t=%0t wait timed out", $time);
        end
    endtask : wait_for
    task automatic pulse(input int w);
        want.ack <= 1'h1;
        cyc(w);
        want.ack <= 1'h0;
        cyc(12);
    endtask : pulse
    // ********
    // Scenarios
    // ********
    task automatic t_regs();
        rd_chk(8'h00, 32'h1);
        wr_reg(8'h18, 32'hFF);
        rd_chk(8'h18, 32'h0);
        rd_chk(8'h40, 32'h0);
        wr_reg(8'h04, 32'h10000);
        rd_chk(8'h04, 32'h7530);
        wr_reg(8'h08, 32'h10000);
        rd_chk(8'h08, 32'hEA60);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_cond();
        wr_reg(8'h00, 32'h1007F);
        for (int i = 0; i < 7; i++) begin
            want.enable <= 7'h7F ^ (7'h01 << i);
            cyc(10);
            chk(cond_met, 1'h0);
            want.enable <= 7'h7F;
            cyc(10);
            chk(cond_met, 1'h1);
        end
        $display("t_cond done");
    endtask : t_cond
    task automatic t_ack();
        int lo;
        for (int m = 0; m < 2; m++) begin
            lo = m ? 35 : 10;
            wr_reg(8'h00, 32'h10003 | (m << 8));
            want.enable <= 7'h03;
            cyc(10);
            pulse((lo - 1) * TC);
            chk(ack_release, 1'h0);
            pulse((lo + 1) * TC);
            chk(ack_release, 1'h1);
            want.enable <= 7'h01;
            cyc(10);
            chk(ack_release, 1'h0);
        end
        want.enable <= 7'h03;
        cyc(10);
        // Lamp may already be mid-phase; measure a whole high phase
        wait_for(2, 1'h0);
        wait_for(2, 1'h1);
        wait_for(2, 1'h0);
        chk(n, 50 * TC);
        pulse(3002 * TC);
        chk(ack_release, 1'h0);
        $display("t_ack done");
    endtask : t_ack
    task automatic t_fix();
        wr_reg(8'h04, 32'h14);
        want.off_in <= 1'h1;
        cyc(10);
        chk(fix_release, 1'h1);
        want.off_in <= 1'h0;
        cyc(40);
        want.off_in <= 1'h1;
        cyc(10);
        chk(fix_release, 1'h1);
        want.off_in <= 1'h0;
        wait_for(3, 1'h0);
        chk(n >= 19 * TC && n <= 20 * TC + 12, 1'h1);
        $display("t_fix done");
    endtask : t_fix
    task automatic t_adj();
        for (int i = 0; i < 4; i++) begin
            wr_reg(8'(8'h08 + 4 * i), 32'(5 << i));
        end
        want.sel <= 4'h5;
        want.enable <= 7'h00;
        want.ctrl_in <= 1'h1;
        cyc(10);
        chk(adj_release, 1'h1);
        want.ctrl_in <= 1'h0;
        cyc(20);
        want.sel <= 4'hF;
        cyc(10);
        chk(time_change, 1'h1);
        // Status: adj_running, time_change and adj_release set
        rd_chk(8'h18, 32'h70);
        wait_for(4, 1'h0);
        chk(n + 32 >= 24 * TC && n + 32 <= 25 * TC + 12, 1'h1);
        chk(time_change, 1'h1);
        want.ctrl_in <= 1'h1;
        cyc(10);
        chk({adj_release, time_change}, 2'h2);
        $display("t_adj done");
    endtask : t_adj
    task automatic t_stop();
        wr_reg(8'h00, 32'h3);
        want.ctrl_in <= 1'h0;
        cyc(10);
        wr_reg(8'h00, 32'h10003);
        cyc(40);
        chk({adj_release, fix_release}, 2'h0);
        want.ctrl_in <= 1'h1;
        cyc(10);
        chk(adj_release, 1'h1);
        $display("t_stop done");
    endtask : t_stop
    task automatic stop_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test
    initial begin
        cyc(3);
        rst_n <= 1'h1;
        cyc(1);
        t_regs();
        t_cond();
        t_ack();
        t_fix();
        t_adj();
        t_stop();
        stop_test();
    end
    // Whole run needs under 20000 cycles
    initial begin
        #1000000;
        failures++;
        stop_test();
    end
endmodule : safety_ack_and_off_delay_tb
